// *** src/pio_defines.svh ***
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// Register indices; byte address is four times the index
`define PIO_IDX_P3_DIR 8'hb4
`define PIO_IDX_P4_DIR 8'hb5
`define PIO_IDX_P3_DATA 8'hb6
`define PIO_IDX_P4_DATA 8'hb7
`define PIO_IDX_P5_DIR 8'hb8
`define PIO_IDX_P6_DIR 8'hb9
`define PIO_IDX_P5_DATA 8'hba
`define PIO_IDX_P6_DATA 8'hbb
`define PIO_IDX_P8_DIR 8'hbd
`define PIO_IDX_P7_PINS 8'hbe
`define PIO_IDX_P8_DATA 8'hbf

// Index width and byte-offset bits
`define PIO_IDX_W 8
`define PIO_IDX_LSB 2
`define PIO_MIN_ADDR_W 10

// Reset values and read patterns
`define PIO_RST_ZERO 8'h00
`define PIO_RD_WO 8'hff
`define PIO_RD_RSVD 8'hff

// Implemented widths of the narrow ports
`define PIO_P5_W 3
`define PIO_P8_W 7

`endif

// *** src/pio_pkg.sv ***
`default_nettype none
package pio_pkg;

    typedef enum logic [3:0] {
        PIO_SEL_NONE = 4'h0,
        PIO_SEL_P3_DIR = 4'h1,
        PIO_SEL_P4_DIR = 4'h2,
        PIO_SEL_P3_DATA = 4'h3,
        PIO_SEL_P4_DATA = 4'h4,
        PIO_SEL_P5_DIR = 4'h5,
        PIO_SEL_P6_DIR = 4'h6,
        PIO_SEL_P5_DATA = 4'h7,
        PIO_SEL_P6_DATA = 4'h8,
        PIO_SEL_P8_DIR = 4'h9,
        PIO_SEL_P7_PINS = 4'ha,
        PIO_SEL_P8_DATA = 4'hb
    } pio_sel_type;

endpackage
`default_nettype wire

// *** src/pio_ports.sv ***
// Notes on behaviour
// - A direction bit of 0 makes its pin an input and a 1 makes it an output.
// - Port 3 output data is an 8-bit read/write register at 0xb6, reset 0.
// - Port 4 output data is an 8-bit read/write register at 0xb7, reset 0.
// - Port 7 pin levels is a read-only register at 0xbe; writes do nothing.
// - Reading port 7 pin levels returns the present level of its 8 pins; the code returns them two pclk cycles late, through two flip-flops.
//
// Added by the designer: the APB slave port.
`include "pio_defines.svh"
`default_nettype none
module pio_ports
    import pio_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe,
    output logic [7:0] p4_out,
    output logic [7:0] p4_oe,
    output logic [`PIO_P5_W-1:0] p5_out,
    output logic [`PIO_P5_W-1:0] p5_oe,
    output logic [7:0] p6_out,
    output logic [7:0] p6_oe,
    input wire logic [7:0] p7_in,
    output logic [`PIO_P8_W-1:0] p8_out,
    output logic [`PIO_P8_W-1:0] p8_oe
);

    if (ADDR_W < `PIO_MIN_ADDR_W)
    begin : g_bad_addr_w
        $error("pio_ports: ADDR_W too small for the register map");
    end

    logic [7:0] port3_direction_ff;
    logic [7:0] port4_direction_ff;
    logic [7:0] port3_output_data_ff;
    logic [7:0] port4_output_data_ff;
    logic [`PIO_P5_W-1:0] port5_direction_ff;
    logic [`PIO_P5_W-1:0] port5_output_data_ff;
    logic [7:0] port6_direction_ff;
    logic [7:0] port6_output_data_ff;
    logic [`PIO_P8_W-1:0] port8_direction_ff;
    logic [`PIO_P8_W-1:0] port8_output_data_ff;
    logic [7:0] p7_meta_ff;
    logic [7:0] p7_sync_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    pio_sel_type sel_ff;
    pio_sel_type nxt_sel;
    logic [31:0] nxt_rdata;
    logic setup;
    logic wr_lane0;
    logic [`PIO_IDX_W-1:0] idx;
    logic aligned;

    assign setup = psel && !penable;
    assign idx = paddr[`PIO_IDX_LSB +: `PIO_IDX_W];
    assign aligned = (paddr[`PIO_IDX_LSB-1:0] == '0) &&
        (paddr >> (`PIO_IDX_LSB + `PIO_IDX_W)) == '0;
    assign wr_lane0 = psel && penable && pready_ff && pwrite && pstrb[0];

    // Address decode
    always_comb
    begin
        nxt_sel = PIO_SEL_NONE;
        if (aligned)
        begin
            case (idx)
                `PIO_IDX_P3_DIR: nxt_sel = PIO_SEL_P3_DIR;
                `PIO_IDX_P4_DIR: nxt_sel = PIO_SEL_P4_DIR;
                `PIO_IDX_P3_DATA: nxt_sel = PIO_SEL_P3_DATA;
                `PIO_IDX_P4_DATA: nxt_sel = PIO_SEL_P4_DATA;
                `PIO_IDX_P5_DIR: nxt_sel = PIO_SEL_P5_DIR;
                `PIO_IDX_P6_DIR: nxt_sel = PIO_SEL_P6_DIR;
                `PIO_IDX_P5_DATA: nxt_sel = PIO_SEL_P5_DATA;
                `PIO_IDX_P6_DATA: nxt_sel = PIO_SEL_P6_DATA;
                `PIO_IDX_P8_DIR: nxt_sel = PIO_SEL_P8_DIR;
                `PIO_IDX_P7_PINS: nxt_sel = PIO_SEL_P7_PINS;
                `PIO_IDX_P8_DATA: nxt_sel = PIO_SEL_P8_DATA;
                default: nxt_sel = PIO_SEL_NONE;
            endcase
        end
    end

    // Read data; direction registers are write-only and read as ones
    always_comb
    begin
        nxt_rdata = '0;
        unique case (nxt_sel)
            PIO_SEL_P3_DATA: nxt_rdata[7:0] = port3_output_data_ff;
            PIO_SEL_P4_DATA: nxt_rdata[7:0] = port4_output_data_ff;
            PIO_SEL_P5_DATA:
            begin
                nxt_rdata[7:0] = `PIO_RD_RSVD;
                nxt_rdata[`PIO_P5_W-1:0] = port5_output_data_ff;
            end
            PIO_SEL_P6_DATA: nxt_rdata[7:0] = port6_output_data_ff;
            PIO_SEL_P8_DATA:
            begin
                nxt_rdata[7:0] = `PIO_RD_RSVD;
                nxt_rdata[`PIO_P8_W-1:0] = port8_output_data_ff;
            end
            PIO_SEL_P7_PINS: nxt_rdata[7:0] = p7_sync_ff;
            PIO_SEL_P3_DIR, PIO_SEL_P4_DIR, PIO_SEL_P5_DIR,
            PIO_SEL_P6_DIR, PIO_SEL_P8_DIR: nxt_rdata[7:0] = `PIO_RD_WO;
            PIO_SEL_NONE: nxt_rdata = '0;
        endcase
    end

    // Bus answer: one access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            sel_ff <= PIO_SEL_NONE;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup && (nxt_sel == PIO_SEL_NONE);
            if (setup)
            begin
                prdata_ff <= pwrite ? '0 : nxt_rdata;
                sel_ff <= nxt_sel;
            end
        end
    end

    // Port 7 pins pass two flip-flops before being read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p7_meta_ff <= `PIO_RST_ZERO;
            p7_sync_ff <= `PIO_RST_ZERO;
        end
        else
        begin
            p7_meta_ff <= p7_in;
            p7_sync_ff <= p7_meta_ff;
        end
    end

    // Direction registers; port 7 has none and ignores writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port3_direction_ff <= `PIO_RST_ZERO;
            port4_direction_ff <= `PIO_RST_ZERO;
            port5_direction_ff <= `PIO_P5_W'(`PIO_RST_ZERO);
            port6_direction_ff <= `PIO_RST_ZERO;
            port8_direction_ff <= `PIO_P8_W'(`PIO_RST_ZERO);
        end
        else if (wr_lane0)
        begin
            if (sel_ff == PIO_SEL_P3_DIR)
                port3_direction_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P4_DIR)
                port4_direction_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P5_DIR)
                port5_direction_ff <= pwdata[`PIO_P5_W-1:0];
            if (sel_ff == PIO_SEL_P6_DIR)
                port6_direction_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P8_DIR)
                port8_direction_ff <= pwdata[`PIO_P8_W-1:0];
        end
    end

    // Output data registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port3_output_data_ff <= `PIO_RST_ZERO;
            port4_output_data_ff <= `PIO_RST_ZERO;
            port5_output_data_ff <= `PIO_P5_W'(`PIO_RST_ZERO);
            port6_output_data_ff <= `PIO_RST_ZERO;
            port8_output_data_ff <= `PIO_P8_W'(`PIO_RST_ZERO);
        end
        else if (wr_lane0)
        begin
            if (sel_ff == PIO_SEL_P3_DATA)
                port3_output_data_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P4_DATA)
                port4_output_data_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P5_DATA)
                port5_output_data_ff <= pwdata[`PIO_P5_W-1:0];
            if (sel_ff == PIO_SEL_P6_DATA)
                port6_output_data_ff <= pwdata[7:0];
            if (sel_ff == PIO_SEL_P8_DATA)
                port8_output_data_ff <= pwdata[`PIO_P8_W-1:0];
        end
    end

    // Pin drivers: enable follows direction, level follows data
    assign p3_out = port3_output_data_ff;
    assign p3_oe = port3_direction_ff;
    assign p4_out = port4_output_data_ff;
    assign p4_oe = port4_direction_ff;
    assign p5_out = port5_output_data_ff;
    assign p5_oe = port5_direction_ff;
    assign p6_out = port6_output_data_ff;
    assign p6_oe = port6_direction_ff;
    assign p8_out = port8_output_data_ff;
    assign p8_oe = port8_direction_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup(logic [`PIO_IDX_W-1:0] ix, logic wr);
        psel && !penable && aligned && idx == ix && pwrite == wr;
    endsequence

    sequence s_write(logic [`PIO_IDX_W-1:0] ix);
        s_setup(ix, 1'b1) ##1 psel && penable && pstrb[0];
    endsequence

    property p_bus_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("pready not a single cycle after setup");

    property p_dir_write;
        s_write(`PIO_IDX_P3_DIR) |=> p3_oe == $past(pwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("port 3 direction write not applied");

    property p_p3_data;
        s_write(`PIO_IDX_P3_DATA) |=> p3_out == $past(pwdata[7:0]);
    endproperty
    a_p3_data: assert property (p_p3_data)
        else $error("port 3 data write not applied");

    property p_p4_data;
        s_setup(`PIO_IDX_P4_DATA, 1'b0) |=> pready &&
            prdata[7:0] == $past(p4_out) && prdata[31:8] == '0;
    endproperty
    a_p4_data: assert property (p_p4_data)
        else $error("port 4 data readback wrong");

    property p_p7_nowrite;
        s_write(`PIO_IDX_P7_PINS) |-> !pslverr ##1
            ($stable(p3_out) && $stable(p4_out) && $stable(p6_out) &&
            $stable(p8_out) && $stable(p3_oe));
    endproperty
    a_p7_nowrite: assert property (p_p7_nowrite)
        else $error("write to port 7 pin levels had an effect");

    property p_p7_read;
        s_setup(`PIO_IDX_P7_PINS, 1'b0) |=> prdata[7:0] == $past(p7_in, 3);
    endproperty
    a_p7_read: assert property (p_p7_read)
        else $error("port 7 read does not match pin levels");

    property p_oe_follow;
        s_write(`PIO_IDX_P6_DIR) |=> p6_oe == $past(pwdata[7:0]) &&
            p6_out == $past(p6_out);
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("port 6 enable does not follow direction");

endmodule
`default_nettype wire

// *** tb/pio_board.sv ***
`default_nettype none
module pio_board
    import pio_pkg::*;
(
    input wire logic pclk,
    input wire logic [7:0] lvl,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    output logic [7:0] p7_in,
    output logic [7:0] p3_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board drives port 7 from the bench's chosen level
    always_ff @(posedge pclk)
    begin
        p7_in <= lvl;
    end
    // Port 3 pins have pull-ups when not driven
    assign p3_pin = (p3_out & p3_oe) | ~p3_oe;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`include "pio_defines.svh"
`default_nettype none
module testbench import pio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] lvl = 8'h00;
    logic [31:0] prdata;
    logic [7:0] d, m, nd, nm;
    logic pready, pslverr;
    logic [7:0] p3_out, p3_oe, p4_out, p4_oe, p6_out, p6_oe, p7_in, p3_pin;
    logic [2:0] p5_out, p5_oe;
    logic [6:0] p8_out, p8_oe;
    logic [33:0] e;
    logic [33:0] q[$];
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    always #4 pclk = ~pclk;

    pio_ports #(.ADDR_W(10)) pio_ports_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .p3_out(p3_out), .p3_oe(p3_oe), .p4_out(p4_out),
        .p4_oe(p4_oe), .p5_out(p5_out), .p5_oe(p5_oe), .p6_out(p6_out),
        .p6_oe(p6_oe), .p7_in(p7_in), .p8_out(p8_out), .p8_oe(p8_oe));
    pio_board pio_board_inst (.pclk(pclk), .lvl(lvl), .p3_out(p3_out),
        .p3_oe(p3_oe), .p7_in(p7_in), .p3_pin(p3_pin));

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; expected answer is queued for the monitor
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
             input logic [31:0] ed, input logic ee);
        q.push_back({~wr, ee, ed});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            e = q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (e[33])
                check("prdata", prdata, e[31:0]);
        end
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            results();
        end
    end

    initial
    begin
        void'($urandom(96));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("p3_oe", {24'h0, p3_oe}, 32'h0);
        apb(0, `PIO_IDX_P3_DATA, 0, 32'h0, 0);
        apb(0, `PIO_IDX_P4_DATA, 0, 32'h0, 0);
        apb(0, `PIO_IDX_P4_DIR, 0, 32'hff, 0);
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            m = 8'($urandom);
            nd = ~d;
            nm = ~m;
            apb(1, `PIO_IDX_P3_DATA, d, 0, 0);
            apb(1, `PIO_IDX_P3_DIR, m, 0, 0);
            apb(1, `PIO_IDX_P4_DATA, nd, 0, 0);
            apb(1, `PIO_IDX_P4_DIR, nm, 0, 0);
            apb(1, `PIO_IDX_P6_DATA, d, 0, 0);
            apb(1, `PIO_IDX_P6_DIR, m, 0, 0);
            apb(0, `PIO_IDX_P3_DATA, 0, d, 0);
            apb(0, `PIO_IDX_P4_DATA, 0, nd, 0);
            apb(0, `PIO_IDX_P6_DATA, 0, d, 0);
            check("p3_oe", p3_oe, m);
            check("p3_pin", p3_pin, d | nm);
            check("p4_oe", p4_oe, nm);
            check("p4_out", p4_out & p4_oe, nd & nm);
            check("p6_oe", p6_oe, m);
            check("p6_out", p6_out & p6_oe, d & m);
        end
        for (int i = 0; i < 4; i++)
        begin
            lvl <= 8'($urandom);
            repeat (4) @(posedge pclk);
            apb(0, `PIO_IDX_P7_PINS, 0, {24'h0, lvl}, 0);
            apb(1, `PIO_IDX_P7_PINS, ~lvl, 0, 0);
            apb(0, `PIO_IDX_P7_PINS, 0, {24'h0, lvl}, 0);
        end
        apb(1, 8'hb0, 32'hff, 0, 1);
        apb(1, `PIO_IDX_P5_DATA, 32'h06, 0, 0);
        apb(1, `PIO_IDX_P5_DIR, 32'h05, 0, 0);
        apb(0, `PIO_IDX_P5_DATA, 0, 32'hfe, 0);
        check("p5_oe", {29'h0, p5_oe}, 32'h5);
        check("p5_out", {29'h0, p5_out}, 32'h6);
        apb(1, `PIO_IDX_P8_DIR, 32'h7f, 0, 0);
        apb(1, `PIO_IDX_P8_DATA, 32'h2a, 0, 0);
        apb(0, `PIO_IDX_P8_DATA, 0, 32'haa, 0);
        check("p8_out", {25'h0, p8_out & p8_oe}, 32'h2a);
        pstrb <= 4'h0;
        apb(1, `PIO_IDX_P3_DATA, nd, 0, 0);
        pstrb <= 4'hf;
        apb(0, `PIO_IDX_P3_DATA, 0, d, 0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `PIO_IDX_P3_DATA, 0, 32'h0, 0);
        check("p8_oe", {25'h0, p8_oe}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
